/* common/sbtc_defs.svh */
`ifndef SBTC_DEFS_SVH
`define SBTC_DEFS_SVH
// ----------------------------------------
// Register addresses
// ----------------------------------------
`define SBTC_ADDR_CONTROL 4'h0
`define SBTC_ADDR_COUNT_LOW 4'h1
`define SBTC_ADDR_COUNT_HIGH 4'h2
`define SBTC_ADDR_IRQ_FLAG 4'h3
`define SBTC_ADDR_IRQ_ENABLE 4'h4
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define SBTC_BIT_COUNT_ENABLE 0
`define SBTC_BIT_CLOCK_SOURCE 1
`define SBTC_BIT_ASYNC_INPUT 2
`define SBTC_BIT_OSC_ENABLE 3
`define SBTC_BIT_PRESCALE_LO 4
`define SBTC_BIT_PRESCALE_HI 5
`define SBTC_BIT_SYSCLK_STATUS 6
`define SBTC_BIT_WIDE_ACCESS 7
`define SBTC_CONTROL_RESET 8'h00
`define SBTC_CONTROL_WRITE_MASK 8'hBF
// ----------------------------------------
// Timing
// ----------------------------------------
`define SBTC_CLK_MHZ 10
`define SBTC_INSTR_DIV 4
`endif

/* common/sbtc_pkg.sv */
package sbtc_pkg;
    typedef logic [7:0] sbtc_byte_t;
    typedef logic [15:0] sbtc_count_t;
    typedef logic [3:0] sbtc_addr_t;
endpackage : sbtc_pkg

/* design/sbtc_edge_sync.sv */
`timescale 1ns/1ps
module sbtc_edge_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic async_i,
    output logic level_o,
    output logic rise_o
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic last;
    } sbtc_sync_state_t;
    sbtc_sync_state_t st;
    sbtc_sync_state_t next_st;
    always_comb begin
        next_st = st;
        next_st.meta = async_i;
        next_st.sync = st.meta;
        next_st.last = st.sync;
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    // Only the second and third stages are ever looked at.
    assign level_o = st.sync;
    assign rise_o = st.sync & ~st.last;
endmodule : sbtc_edge_sync

/* design/sbtc_timer.sv */
// Functional notes
// - Count up, wrap, latch overflow flag.
// - Interrupt only while enable bit set.
// - Count only while count enable set.
// - Bit 7 selects buffered wide access.
// - Bit 6 shows system clock source.
// - Prescale divides by 1, 2, 4, 8.
// - Bit 3 runs or stops oscillator.
// - Bit 2 selects unsynchronised external clock.
// - Bit 1 selects external or instruction clock.
// - Advance per instruction cycle or external rising edge.
// - Oscillator pins forced input, read zero.
// - Capture unit trigger clears the count.
// - Oscillator keeps running in power modes.
// - Status bit tracks clock after failure.
// - Oscillator pins serve as clock source.
// - Low read copies high; low write loads.
// - Low writes and plain high writes clear the prescaler.
// - Write beats trigger; trigger sets no flag.
`timescale 1ns/1ps
`include "sbtc_defs.svh"
module sbtc_timer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire sbtc_pkg::sbtc_addr_t addr_i,
    input wire sbtc_pkg::sbtc_byte_t wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output sbtc_pkg::sbtc_byte_t rdata_o,
    input wire logic ext_clk_i,
    input wire logic osc_in_pin_i,
    input wire logic sysclk_from_osc_i,
    input wire logic event_trigger_i,
    input wire logic [1:0] pin_direction_bits_i,
    input wire logic [1:0] port_read_i,
    output logic [1:0] port_read_o,
    output logic [1:0] pin_output_enable_o,
    output logic osc_run_o,
    output logic irq_o
);
    import sbtc_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        sbtc_byte_t control;
        sbtc_count_t count;
        sbtc_byte_t high_buffer;
        logic [2:0] prescale_count;
        logic [1:0] instr_div;
        logic overflow_flag;
        logic overflow_irq_enable;
        logic [1:0] status_meta;
        logic status_sync;
        sbtc_byte_t rdata;
        logic [1:0] port_read;
        logic [1:0] pin_oe;
        logic osc_run;
        logic irq;
    } sbtc_state_t;

    sbtc_state_t st;
    sbtc_state_t next_st;

    logic ext_level;
    logic ext_rise;
    logic osc_level;
    logic osc_rise;
    logic [1:0] port_level;
    logic [1:0] raw_sync_meta;
    logic [1:0] raw_sync;
    logic [1:0] raw_last;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    sbtc_edge_sync u_ext_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(ext_clk_i),
        .level_o(ext_level),
        .rise_o(ext_rise)
    );
    sbtc_edge_sync u_osc_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(osc_in_pin_i),
        .level_o(osc_level),
        .rise_o(osc_rise)
    );
    sbtc_edge_sync u_port0_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(port_read_i[0]),
        .level_o(port_level[0]),
        .rise_o()
    );
    sbtc_edge_sync u_port1_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(port_read_i[1]),
        .level_o(port_level[1]),
        .rise_o()
    );

    // ----------------------------------------
    // Unsynchronised edge path
    // ----------------------------------------
    // Even the unsynchronised choice passes two flops, since every pin is foreign
    // to this clock; it only skips the shared edge synchronisers. Each pin keeps
    // its own edge history, so switching the source never fakes a rising edge.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            raw_sync_meta <= 2'h0;
            raw_sync <= 2'h0;
            raw_last <= 2'h0;
        end else begin
            raw_sync_meta <= {osc_in_pin_i, ext_clk_i};
            raw_sync <= raw_sync_meta;
            raw_last <= raw_sync;
        end
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    logic instr_tick;
    logic src_tick;
    logic sync_rise;
    logic raw_rise;
    logic [2:0] prescale_top;
    logic count_tick;
    logic write_low;
    logic wide;
    logic wrap;

    always_comb begin
        next_st = st;
        // ----------------------------------------
        // Clock source and prescaler
        // ----------------------------------------
        // The instruction divider runs free, so timer mode needs no start-up alignment.
        instr_tick = (st.instr_div == 2'(`SBTC_INSTR_DIV - 1));
        sync_rise = st.control[`SBTC_BIT_OSC_ENABLE] ? osc_rise : ext_rise;
        raw_rise = st.control[`SBTC_BIT_OSC_ENABLE] ? (raw_sync[1] & ~raw_last[1])
            : (raw_sync[0] & ~raw_last[0]);
        if (st.control[`SBTC_BIT_CLOCK_SOURCE]) begin
            src_tick = st.control[`SBTC_BIT_ASYNC_INPUT] ? raw_rise : sync_rise;
        end else begin
            src_tick = instr_tick;
        end
        prescale_top = 3'((1 << st.control[`SBTC_BIT_PRESCALE_HI:`SBTC_BIT_PRESCALE_LO]) - 1);
        count_tick = 1'b0;
        wide = st.control[`SBTC_BIT_WIDE_ACCESS];
        write_low = wr_i && (addr_i == `SBTC_ADDR_COUNT_LOW);
        next_st.instr_div = st.instr_div + 2'h1;

        if (st.control[`SBTC_BIT_COUNT_ENABLE] && src_tick) begin
            if (st.prescale_count >= prescale_top) begin
                next_st.prescale_count = 3'h0;
                count_tick = 1'b1;
            end else begin
                next_st.prescale_count = st.prescale_count + 3'h1;
            end
        end

        // ----------------------------------------
        // Counter
        // ----------------------------------------
        wrap = count_tick && (st.count == 16'hFFFF);
        if (count_tick) begin
            next_st.count = st.count + 16'h0001;
        end
        if (wrap) begin
            next_st.overflow_flag = 1'b1;
        end

        if (event_trigger_i) begin
            next_st.count = 16'h0000;
        end

        // ----------------------------------------
        // Register reads
        // ----------------------------------------
        next_st.rdata = 8'h00;
        if (rd_i) begin
            unique case (addr_i)
                `SBTC_ADDR_CONTROL: begin
                    next_st.rdata = st.control;
                end
                `SBTC_ADDR_COUNT_LOW: begin
                    next_st.rdata = st.count[7:0];
                    if (wide) begin
                        next_st.high_buffer = st.count[15:8];
                    end
                end
                `SBTC_ADDR_COUNT_HIGH: begin
                    next_st.rdata = wide ? st.high_buffer : st.count[15:8];
                end
                `SBTC_ADDR_IRQ_FLAG: begin
                    next_st.rdata = {7'h00, st.overflow_flag};
                end
                `SBTC_ADDR_IRQ_ENABLE: begin
                    next_st.rdata = {7'h00, st.overflow_irq_enable};
                end
                default: begin
                    next_st.rdata = 8'h00;
                end
            endcase
        end

        // ----------------------------------------
        // Register writes
        // ----------------------------------------
        if (wr_i) begin
            unique case (addr_i)
                `SBTC_ADDR_CONTROL: begin
                    next_st.control = (wdata_i & `SBTC_CONTROL_WRITE_MASK)
                        | (st.control & ~`SBTC_CONTROL_WRITE_MASK);
                end
                `SBTC_ADDR_COUNT_LOW: begin
                    next_st.count[7:0] = wdata_i;
                    next_st.count[15:8] = wide ? st.high_buffer : st.count[15:8];
                end
                `SBTC_ADDR_COUNT_HIGH: begin
                    if (wide) begin
                        next_st.high_buffer = wdata_i;
                    end else begin
                        next_st.count[15:8] = wdata_i;
                        // On a trigger keep the low byte as it stood; with no trigger it still takes any count tick.
                        next_st.count[7:0] = event_trigger_i ? st.count[7:0] : next_st.count[7:0];
                    end
                end
                `SBTC_ADDR_IRQ_FLAG: begin
                    // A wrap in this cycle wins over the software clear.
                    if (!wdata_i[0] && !wrap) begin
                        next_st.overflow_flag = 1'b0;
                    end else if (wdata_i[0]) begin
                        next_st.overflow_flag = 1'b1;
                    end
                end
                `SBTC_ADDR_IRQ_ENABLE: begin
                    next_st.overflow_irq_enable = wdata_i[0];
                end
                default: begin
                end
            endcase
        end

        // Low write or plain (non-wide) high write clears prescaler
        // A plain high write is a live counter write, so it restarts the prescaler too.
        if (write_low || (wr_i && addr_i == `SBTC_ADDR_COUNT_HIGH && !wide)) begin
            next_st.prescale_count = 3'h0;
        end

        // ----------------------------------------
        // Status and pins
        // ----------------------------------------
        // The status level comes from the clock switch, outside this clock, so it
        // is synchronised first and software sees it a few clocks late.
        // System clock status
        next_st.status_meta = {st.status_meta[0], sysclk_from_osc_i};
        next_st.status_sync = st.status_meta[1];
        next_st.control[`SBTC_BIT_SYSCLK_STATUS] = st.status_sync;

        next_st.osc_run = next_st.control[`SBTC_BIT_OSC_ENABLE];
        next_st.pin_oe = next_st.control[`SBTC_BIT_OSC_ENABLE] ? 2'h0 : ~pin_direction_bits_i;
        next_st.port_read = next_st.control[`SBTC_BIT_OSC_ENABLE] ? 2'h0 : port_level;
        next_st.irq = next_st.overflow_flag & next_st.overflow_irq_enable;
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
            st.control <= `SBTC_CONTROL_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign rdata_o = st.rdata;
    assign port_read_o = st.port_read;
    assign pin_output_enable_o = st.pin_oe;
    assign osc_run_o = st.osc_run;
    assign irq_o = st.irq;
endmodule : sbtc_timer

/* testbench/sbtc_clk_src.sv */
`timescale 1ns/1ps
module sbtc_clk_src #(
    parameter int HALF_NS = 365
) (
    input wire logic run_i,
    input wire logic sel_osc_i,
    output logic ext_clk_o,
    output logic osc_o,
    output int edges_o = 0
);
    logic ph = 1'b0;
    // Whole pulses only, so no high phase is ever cut shorter than a clock.
    always begin
        wait (run_i);
        #HALF_NS ph = 1'b1;
        edges_o = edges_o + 1;
        #HALF_NS ph = 1'b0;
    end
    assign ext_clk_o = ph & ~sel_osc_i;
    assign osc_o = ph & sel_osc_i;
endmodule : sbtc_clk_src

/* testbench/sbtc_timer_props.sv */
`timescale 1ns/1ps
`include "sbtc_defs.svh"
module sbtc_timer_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire sbtc_pkg::sbtc_addr_t addr_i,
    input wire sbtc_pkg::sbtc_byte_t wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire sbtc_pkg::sbtc_byte_t rdata_o,
    input wire logic [1:0] pin_direction_bits_i,
    input wire logic [1:0] port_read_o,
    input wire logic [1:0] pin_output_enable_o,
    input wire logic event_trigger_i,
    input wire logic osc_run_o,
    input wire logic irq_o
);
    import sbtc_pkg::*;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    property p_reset;
        $fell(rst_i) |-> !irq_o && !osc_run_o && rdata_o == 8'h00;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
    property p_idle;
        !rd_i |=> rdata_o == 8'h00;
    endproperty
    a_idle: assert property (p_idle) else $error("read data without read");
    property p_unmapped;
        rd_i && addr_i > `SBTC_ADDR_IRQ_ENABLE |=> rdata_o == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_osc_write;
        wr_i && addr_i == `SBTC_ADDR_CONTROL ##1 !(wr_i && addr_i == `SBTC_ADDR_CONTROL)
            |=> osc_run_o == $past(wdata_i[3], 2);
    endproperty
    a_osc_write: assert property (p_osc_write) else $error("oscillator run wrong");
    property p_osc_read;
        rd_i && addr_i == `SBTC_ADDR_CONTROL && !$past(wr_i) |=> rdata_o[3] == $past(osc_run_o);
    endproperty
    a_osc_read: assert property (p_osc_read) else $error("oscillator bit readback wrong");
    property p_pins_osc;
        osc_run_o && $past(osc_run_o) |-> pin_output_enable_o == 2'b00 && port_read_o == 2'b00;
    endproperty
    a_pins_osc: assert property (p_pins_osc) else $error("pins not released");
    property p_dir;
        !osc_run_o && !$past(osc_run_o) && !$past(rst_i) && $stable(pin_direction_bits_i)
            |-> pin_output_enable_o == ~pin_direction_bits_i;
    endproperty
    a_dir: assert property (p_dir) else $error("output enable ignores direction");
    property p_irq_mask;
        wr_i && addr_i == `SBTC_ADDR_IRQ_ENABLE && !wdata_i[0]
            ##1 !(wr_i && addr_i == `SBTC_ADDR_IRQ_ENABLE) |=> !irq_o;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt seen");
    property p_buf;
        wr_i && addr_i == `SBTC_ADDR_COUNT_HIGH ##1 rd_i && addr_i == `SBTC_ADDR_COUNT_HIGH
            |=> rdata_o == $past(wdata_i, 2);
    endproperty
    a_buf: assert property (p_buf) else $error("high buffer readback wrong");
    property p_trig;
        event_trigger_i && !wr_i ##1 event_trigger_i && rd_i && addr_i == `SBTC_ADDR_COUNT_LOW
            |=> rdata_o == 8'h00;
    endproperty
    a_trig: assert property (p_trig) else $error("trigger did not clear count");
endmodule : sbtc_timer_props
bind sbtc_timer sbtc_timer_props sbtc_timer_props_i (.clk_i, .rst_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .pin_direction_bits_i, .port_read_o, .pin_output_enable_o,
    .event_trigger_i, .osc_run_o, .irq_o);

/* testbench/tb.sv */
`timescale 1ns/1ps
`include "sbtc_defs.svh"
module tb;
    import sbtc_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    sbtc_addr_t addr_i = 4'h0;
    sbtc_byte_t wdata_i = 8'h00;
    sbtc_byte_t rdata_o;
    sbtc_byte_t v;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic trig = 1'b0;
    logic sysclk = 1'b0;
    logic run = 1'b0;
    logic sel = 1'b0;
    logic [1:0] dir = 2'b01;
    logic [1:0] pin_i = 2'b10;
    logic [1:0] pin_o;
    logic [1:0] oe_o;
    logic ext_clk;
    logic osc_in;
    logic osc_run_o;
    logic irq_o;
    int edges;
    int e0;
    int fails = 0;
    int tests_run = 0;
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    sbtc_timer sbtc_timer_i (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_clk_i(ext_clk), .osc_in_pin_i(osc_in),
        .sysclk_from_osc_i(sysclk), .event_trigger_i(trig), .pin_direction_bits_i(dir),
        .port_read_i(pin_i), .port_read_o(pin_o), .pin_output_enable_o(oe_o),
        .osc_run_o(osc_run_o), .irq_o(irq_o));
    sbtc_clk_src sbtc_clk_src_i (.run_i(run), .sel_osc_i(sel), .ext_clk_o(ext_clk),
        .osc_o(osc_in), .edges_o(edges));
    task automatic chk(input sbtc_byte_t g, input sbtc_byte_t e);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic cyc(input int n);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        repeat (n) @(posedge clk_i);
    endtask : cyc
    task automatic wr(input sbtc_addr_t a, input sbtc_byte_t d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        rd_i <= 1'b0;
        @(posedge clk_i);
    endtask : wr
    task automatic rd(input sbtc_addr_t a, input sbtc_byte_t e);
        addr_i <= a;
        rd_i <= 1'b1;
        wr_i <= 1'b0;
        @(posedge clk_i);
        #1;
        v = rdata_o;
        chk(v, e);
    endtask : rd
    task automatic end_of_test;
        if (fails == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        cyc(10);
        rst_i <= 1'b0;
        cyc(1);
        rd(`SBTC_ADDR_CONTROL, 8'h00);
        rd(`SBTC_ADDR_IRQ_FLAG, 8'h00);
        rd(4'hF, 8'h00);
        wr(`SBTC_ADDR_CONTROL, 8'hFF);
        rd(`SBTC_ADDR_CONTROL, 8'hBF);
        sysclk <= 1'b1;
        cyc(5);
        rd(`SBTC_ADDR_CONTROL, 8'hFF);
        chk({6'h00, oe_o}, 8'h00);
        chk({6'h00, pin_o}, 8'h00);
        chk({7'h00, osc_run_o}, 8'h01);
        sysclk <= 1'b0;
        wr(`SBTC_ADDR_CONTROL, 8'h00);
        cyc(5);
        chk({6'h00, oe_o}, 8'h02);
        chk({6'h00, pin_o}, 8'h02);
        chk({7'h00, osc_run_o}, 8'h00);
        wr(`SBTC_ADDR_COUNT_HIGH, 8'h12);
        wr(`SBTC_ADDR_COUNT_LOW, 8'h34);
        cyc(20);
        rd(`SBTC_ADDR_COUNT_LOW, 8'h34);
        rd(`SBTC_ADDR_COUNT_HIGH, 8'h12);
        trig <= 1'b1;
        cyc(1);
        rd(`SBTC_ADDR_COUNT_LOW, 8'h00);
        trig <= 1'b0;
        rd(`SBTC_ADDR_IRQ_FLAG, 8'h00);
        trig <= 1'b1;
        wr(`SBTC_ADDR_COUNT_LOW, 8'h55);
        trig <= 1'b0;
        rd(`SBTC_ADDR_COUNT_LOW, 8'h55);
        for (int p = 0; p < 4; p++) begin
            wr(`SBTC_ADDR_COUNT_LOW, 8'h00);
            wr(`SBTC_ADDR_CONTROL, {2'b00, 2'(p), 4'h1});
            // A window of 64 clocks holds a whole number of instruction cycles.
            cyc(63);
            wr(`SBTC_ADDR_CONTROL, 8'h00);
            rd(`SBTC_ADDR_COUNT_LOW, 8'((64 / `SBTC_INSTR_DIV) >> p));
            chk({7'h00, v + 8'h01 >= (8'h10 >> p) && v <= (8'h11 >> p)}, 8'h01);
        end
        wr(`SBTC_ADDR_COUNT_HIGH, 8'hFF);
        wr(`SBTC_ADDR_COUNT_LOW, 8'hFF);
        wr(`SBTC_ADDR_IRQ_ENABLE, 8'h01);
        wr(`SBTC_ADDR_CONTROL, 8'h01);
        cyc(12);
        rd(`SBTC_ADDR_IRQ_FLAG, 8'h01);
        chk({7'h00, irq_o}, 8'h01);
        wr(`SBTC_ADDR_IRQ_ENABLE, 8'h00);
        cyc(2);
        chk({7'h00, irq_o}, 8'h00);
        wr(`SBTC_ADDR_CONTROL, 8'h00);
        wr(`SBTC_ADDR_IRQ_FLAG, 8'h00);
        wr(`SBTC_ADDR_CONTROL, 8'h80);
        wr(`SBTC_ADDR_COUNT_HIGH, 8'hAB);
        wr(`SBTC_ADDR_COUNT_LOW, 8'hCD);
        wr(`SBTC_ADDR_COUNT_HIGH, 8'h11);
        rd(`SBTC_ADDR_COUNT_HIGH, 8'h11);
        rd(`SBTC_ADDR_COUNT_LOW, 8'hCD);
        rd(`SBTC_ADDR_COUNT_HIGH, 8'hAB);
        wr(`SBTC_ADDR_CONTROL, 8'h00);
        rd(`SBTC_ADDR_COUNT_HIGH, 8'hAB);
        for (int i = 0; i < 3; i++) begin
            sel <= i == 2;
            wr(`SBTC_ADDR_COUNT_LOW, 8'h00);
            wr(`SBTC_ADDR_CONTROL, 8'h03 | 8'(i << 2));
            // Idle 20 clocks before the pin clock starts; only the last pass selects the crystal.
            cyc(20);
            e0 = edges;
            run <= 1'b1;
            cyc(40);
            run <= 1'b0;
            cyc(12);
            rd(`SBTC_ADDR_COUNT_LOW, 8'(edges - e0));
        end
        cyc(2);
        end_of_test();
    end
endmodule : tb
